// ==== common/ppc_map.svh ====
// Register offsets, field positions and constants of the PASID cache control block
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH
// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define PPC_OFF_CTRL      4'h0
`define PPC_OFF_STATUS    4'h4
`define PPC_OFF_INV       4'h8
// ****************************************************************
// Fields and reset values
// ****************************************************************
`define PPC_CTRL_CACHING_MODE_BIT 0
`define PPC_CTRL_TABLE_MODE_LO    1
`define PPC_CTRL_TABLE_MODE_HI    2
`define PPC_INV_ALL_BIT           31
`define PPC_CACHING_MODE_RST      1'h0
`define PPC_TABLE_MODE_RST        2'h0
`define PPC_TABLE_MODE_SCALABLE   2'h1
`define PPC_DID_FAULT     16'h0000
`define PPC_ENTRIES       8
`endif

// ==== common/ppc_pkg.sv ====
// Types shared by the PASID cache control block
package ppc_pkg;
  typedef logic [19:0] ppc_pasid_t;
  typedef logic [15:0] ppc_sid_t;
  typedef logic [15:0] ppc_did_t;
  typedef logic [63:0] ppc_data_t;
  typedef logic [2:0]  ppc_idx_t;
  typedef logic [3:0]  ppc_cnt_t;
endpackage

// ==== src/ppc_cache.sv ====
// PASID-table entry cache with tagging, fault caching and Avalon-MM control
// Overview of operation
// - Cache used only when table mode field selects scalable mode 01b.
// - Request without PASID looks up with context entry's default PASID.
// - Caching mode 0: faulting PASID-table entries are never cached.
// - Caching mode 1: faulting entries may be cached, tagged domain 0.
// - New non-faulting cache entries take their domain tag from the context entry.
// - Same PASID from many sources must not thrash its own entries.
// - Entries are tagged with the requester source of the fetching request.
`timescale 1ns/100ps
`default_nettype none
`include "ppc_map.svh"

module ppc_cache (
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic               lk_valid,
  input  wire logic               lk_has_pasid,
  input  wire ppc_pkg::ppc_pasid_t lk_pasid,
  input  wire ppc_pkg::ppc_sid_t  lk_sid,
  input  wire ppc_pkg::ppc_pasid_t ctx_default_pasid,
  input  wire ppc_pkg::ppc_did_t  ctx_did,
  output logic                    lk_done_q,
  output logic                    lk_hit_q,
  output logic                    lk_fault_q,
  output ppc_pkg::ppc_pasid_t     lk_pasid_q,
  output ppc_pkg::ppc_did_t       lk_did_q,
  output ppc_pkg::ppc_data_t      lk_data_q,
  input  wire logic               fill_valid,
  input  wire logic               fill_fault,
  input  wire ppc_pkg::ppc_pasid_t fill_pasid,
  input  wire ppc_pkg::ppc_sid_t  fill_sid,
  input  wire ppc_pkg::ppc_data_t fill_data
);
  localparam int N = `PPC_ENTRIES;

  // ****************************************************************
  // Control registers and Avalon slave
  // ****************************************************************
  logic                caching_mode_q;
  logic [1:0]          table_mode_q;
  logic                ack_q;
  logic [31:0]         rdata_q;
  logic [N-1:0]        valid_q;
  ppc_pkg::ppc_pasid_t pasid_q [N];
  ppc_pkg::ppc_sid_t   sid_q   [N];
  ppc_pkg::ppc_did_t   did_q   [N];
  ppc_pkg::ppc_data_t  data_q  [N];
  logic [N-1:0]        flt_q;
  ppc_pkg::ppc_idx_t   rr_q;

  wire       acc_req   = avs_read | avs_write;
  wire       wr_take   = avs_write & ack_q;
  wire       sel_ctrl  = avs_address == `PPC_OFF_CTRL;
  wire       sel_stat  = avs_address == `PPC_OFF_STATUS;
  wire       sel_inv   = avs_address == `PPC_OFF_INV;
  wire       scalable  = table_mode_q == `PPC_TABLE_MODE_SCALABLE;
  wire       inv_go    = wr_take & sel_inv;
  wire       inv_all   = inv_go & avs_writedata[`PPC_INV_ALL_BIT];
  wire [19:0] inv_pasid = avs_writedata[19:0];

  // One wait cycle keeps read data registered
  assign avs_waitrequest = acc_req & ~ack_q;
  assign avs_readdata    = rdata_q;

  function automatic ppc_pkg::ppc_cnt_t pop(input logic [N-1:0] v);
    ppc_pkg::ppc_cnt_t c;
    c = '0;
    for (int i = 0; i < N; i++) begin
      c = c + ppc_pkg::ppc_cnt_t'(v[i]);
    end
    return c;
  endfunction

  wire ppc_pkg::ppc_cnt_t used_cnt = pop(valid_q);
  wire [31:0] rd_mux = sel_ctrl ? {29'h0, table_mode_q, caching_mode_q} :
                       sel_stat ? {28'h0, used_cnt} : 32'h0;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
      caching_mode_q <= `PPC_CACHING_MODE_RST;
      table_mode_q   <= `PPC_TABLE_MODE_RST;
    end else begin
      ack_q   <= acc_req & ~ack_q;
      rdata_q <= (avs_read & ~ack_q) ? rd_mux : rdata_q;
      if (wr_take && sel_ctrl) begin
        caching_mode_q <= avs_writedata[`PPC_CTRL_CACHING_MODE_BIT];
        table_mode_q   <= avs_writedata[`PPC_CTRL_TABLE_MODE_HI:`PPC_CTRL_TABLE_MODE_LO];
      end
    end
  end

  // ****************************************************************
  // Tag match, victim choice and fill
  // ****************************************************************
  // source-tagged match
  function automatic logic [N-1:0] hit_vec(input logic [N-1:0] v, input logic [19:0] p,
                                           input logic [15:0] s, input ppc_pkg::ppc_pasid_t tp [N],
                                           input ppc_pkg::ppc_sid_t ts [N]);
    logic [N-1:0] h;
    h = '0;
    for (int i = 0; i < N; i++) begin
      h[i] = v[i] & (tp[i] == p) & (ts[i] == s);
    end
    return h;
  endfunction

  function automatic ppc_pkg::ppc_idx_t first_idx(input logic [N-1:0] v);
    ppc_pkg::ppc_idx_t k;
    k = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        k = ppc_pkg::ppc_idx_t'(i);
      end
    end
    return k;
  endfunction

  wire ppc_pkg::ppc_pasid_t key_pasid = lk_has_pasid ? lk_pasid : ctx_default_pasid;
  wire [N-1:0] lk_vec   = hit_vec(valid_q, key_pasid, lk_sid, pasid_q, sid_q);
  wire [N-1:0] fl_vec   = hit_vec(valid_q, fill_pasid, fill_sid, pasid_q, sid_q);
  wire         lk_any   = |lk_vec;
  wire ppc_pkg::ppc_idx_t lk_idx = first_idx(lk_vec);
  // matching entry first, then free slots, per-source tags keep one PASID apart
  wire         has_free = ~&valid_q;
  wire ppc_pkg::ppc_idx_t vict  = |fl_vec ? first_idx(fl_vec) : has_free ? first_idx(~valid_q) : rr_q;
  // no faulting fill under caching mode 0
  wire         fill_ok  = fill_valid & scalable & (~fill_fault | caching_mode_q);
  // faulting entries carry the reserved domain
  // domain tag from the context entry
  wire ppc_pkg::ppc_did_t fill_did = fill_fault ? `PPC_DID_FAULT : ctx_did;

  generate
    for (genvar g = 0; g < N; g++) begin : g_ent
      wire wr_me  = fill_ok & (vict == ppc_pkg::ppc_idx_t'(g));
      wire inv_me = inv_all | (inv_go & (pasid_q[g] == inv_pasid));
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          valid_q[g] <= 1'b0;
          flt_q[g]   <= 1'b0;
          pasid_q[g] <= '0;
          sid_q[g]   <= '0;
          did_q[g]   <= '0;
          data_q[g]  <= '0;
        end else begin
          // Fill beats a same-cycle invalidate
          valid_q[g] <= wr_me | (valid_q[g] & ~inv_me);
          if (wr_me) begin
            flt_q[g]   <= fill_fault;
            pasid_q[g] <= fill_pasid;
            sid_q[g]   <= fill_sid;
            did_q[g]   <= fill_did;
            data_q[g]  <= fill_data;
          end
        end
      end
      property p_flt_did;
        @(posedge core_clk) disable iff (!arst_n)
          valid_q[g] && flt_q[g] |-> did_q[g] == `PPC_DID_FAULT;
      endproperty
      a_flt_did: assert property (p_flt_did) else $error("faulting entry not tagged domain 0");
      property p_did_ctx;
        @(posedge core_clk) disable iff (!arst_n)
          $rose(valid_q[g]) && !flt_q[g] |-> did_q[g] == $past(ctx_did);
      endproperty
      a_did_ctx: assert property (p_did_ctx) else $error("new entry domain not from context");
      property p_sid_tag;
        @(posedge core_clk) disable iff (!arst_n)
          $rose(valid_q[g]) |-> sid_q[g] == $past(fill_sid) && pasid_q[g] == $past(fill_pasid);
      endproperty
      a_sid_tag: assert property (p_sid_tag) else $error("entry tags differ from fill");
    end
  endgenerate

  // ****************************************************************
  // Lookup result and replacement pointer
  // ****************************************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lk_done_q  <= 1'b0;
      lk_hit_q   <= 1'b0;
      lk_fault_q <= 1'b0;
      lk_pasid_q <= '0;
      lk_did_q   <= '0;
      lk_data_q  <= '0;
      rr_q       <= '0;
    end else begin
      lk_done_q  <= lk_valid;
      lk_hit_q   <= lk_valid & scalable & lk_any;
      lk_fault_q <= lk_valid & scalable & lk_any & flt_q[lk_idx];
      lk_pasid_q <= key_pasid;
      lk_did_q   <= did_q[lk_idx];
      lk_data_q  <= data_q[lk_idx];
      rr_q       <= (fill_ok & ~has_free & ~|fl_vec) ? rr_q + 3'h1 : rr_q;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // legacy mode never hits
  property p_legacy;
    @(posedge core_clk) disable iff (!arst_n)
      !scalable |=> !lk_hit_q;
  endproperty
  a_legacy: assert property (p_legacy) else $error("hit outside scalable mode");

  property p_dflt;
    @(posedge core_clk) disable iff (!arst_n)
      lk_valid && !lk_has_pasid |=> lk_pasid_q == $past(ctx_default_pasid);
  endproperty
  a_dflt: assert property (p_dflt) else $error("default PASID not used");

  property p_nofault;
    @(posedge core_clk) disable iff (!arst_n)
      fill_valid && fill_fault && !caching_mode_q && !inv_go |=> valid_q == $past(valid_q);
  endproperty
  a_nofault: assert property (p_nofault) else $error("fault cached with caching mode 0");

  // new source fills a free slot
  property p_nothrash;
    @(posedge core_clk) disable iff (!arst_n)
      fill_ok && has_free && !(|fl_vec) && !inv_go |=> used_cnt == $past(used_cnt) + 4'h1;
  endproperty
  a_nothrash: assert property (p_nothrash) else $error("fill evicted while slot free");

  property p_wait;
    @(posedge core_clk) disable iff (!arst_n)
      acc_req && !ack_q |-> avs_waitrequest ##1 (!acc_req || !avs_waitrequest);
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest timing wrong");

  property p_invall;
    @(posedge core_clk) disable iff (!arst_n)
      inv_all && !fill_ok |=> valid_q == '0;
  endproperty
  a_invall: assert property (p_invall) else $error("invalidate all left entries");
endmodule
`default_nettype wire

// ==== testbench/ppc_host_model.sv ====
// Host-side model supplying PASID-table entries and context domain to the cache
`timescale 1ns/100ps
`default_nettype none
module ppc_host_model (
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  input  wire logic                go,
  input  wire logic                bad,
  input  wire ppc_pkg::ppc_pasid_t pasid,
  input  wire ppc_pkg::ppc_sid_t   sid,
  input  wire ppc_pkg::ppc_did_t   did,
  output logic                     fill_valid,
  output logic                     fill_fault,
  output ppc_pkg::ppc_pasid_t      fill_pasid,
  output ppc_pkg::ppc_sid_t        fill_sid,
  output ppc_pkg::ppc_data_t       fill_data,
  output ppc_pkg::ppc_did_t        ctx_did
);
  // ****************************************************************
  // Entry source
  // ****************************************************************
  // nonzero domain
  // all fields in one update
  // Fields scrambled between fills to catch late sampling
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fill_valid <= 1'b0;
      fill_fault <= 1'b0;
      fill_pasid <= 20'h00000;
      fill_sid <= 16'h0000;
      fill_data <= 64'h0;
      ctx_did <= 16'h0001;
    end else if (go) begin
      fill_valid <= 1'b1;
      fill_fault <= bad;
      fill_pasid <= pasid;
      fill_sid <= sid;
      fill_data <= {28'h0, pasid, did};
      ctx_did <= (did == 16'h0000) ? 16'h0001 : did;
    end else begin
      fill_valid <= 1'b0;
      fill_fault <= ~fill_fault;
      fill_pasid <= ~fill_pasid;
      fill_sid <= ~fill_sid;
      fill_data <= ~fill_data;
      ctx_did <= ~ctx_did;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/pasid_context_cache_control_test.sv ====
// Self-checking bench for the PASID cache control block
`timescale 1ns/100ps
`default_nettype none
module pasid_context_cache_control_test;
  logic                core_clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic                lk_valid, lk_has_pasid, lk_done_q, lk_hit_q, lk_fault_q;
  logic                go, bad, fill_valid, fill_fault;
  logic [3:0]          avs_address;
  logic [31:0]         avs_writedata, avs_readdata, rd;
  ppc_pkg::ppc_pasid_t lk_pasid, ctx_default_pasid, lk_pasid_q, fill_pasid, pasid;
  ppc_pkg::ppc_sid_t   lk_sid, fill_sid, sid;
  ppc_pkg::ppc_did_t   ctx_did, lk_did_q, did;
  ppc_pkg::ppc_data_t  lk_data_q, fill_data;
  int                  fail_count, comparisons;
  ppc_cache i_ppc_cache (
    .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lk_valid(lk_valid), .lk_has_pasid(lk_has_pasid),
    .lk_pasid(lk_pasid), .lk_sid(lk_sid), .ctx_default_pasid(ctx_default_pasid), .ctx_did(ctx_did),
    .lk_done_q(lk_done_q), .lk_hit_q(lk_hit_q), .lk_fault_q(lk_fault_q), .lk_pasid_q(lk_pasid_q),
    .lk_did_q(lk_did_q), .lk_data_q(lk_data_q), .fill_valid(fill_valid), .fill_fault(fill_fault),
    .fill_pasid(fill_pasid), .fill_sid(fill_sid), .fill_data(fill_data)
  );
  ppc_host_model i_ppc_host_model (
    .core_clk(core_clk), .arst_n(arst_n), .go(go), .bad(bad), .pasid(pasid), .sid(sid), .did(did),
    .fill_valid(fill_valid), .fill_fault(fill_fault), .fill_pasid(fill_pasid), .fill_sid(fill_sid),
    .fill_data(fill_data), .ctx_did(ctx_did)
  );
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic stop_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Waits on waitrequest, bounded so a stuck slave ends the run
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= wd;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      fail_count++;
      stop_test();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Without PASID the lane carries a decoy, the context the real key
  task automatic look(input logic h, input logic [19:0] p, input logic [15:0] s);
    @(posedge core_clk);
    lk_valid <= 1'b1;
    lk_has_pasid <= h;
    lk_pasid <= h ? p : ~p;
    ctx_default_pasid <= h ? ~p : p;
    lk_sid <= s;
    @(posedge core_clk);
    lk_valid <= 1'b0;
    @(negedge core_clk);
    chk("done", 1, lk_done_q);
    chk("key", p, lk_pasid_q);
  endtask
  task automatic put(input logic b, input logic [19:0] p, input logic [15:0] s, input logic [15:0] d);
    @(posedge core_clk);
    go <= 1'b1;
    bad <= b;
    pasid <= p;
    sid <= s;
    did <= d;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    bus(1'b1, 4'hC, 32'hFFFFFFFF);
    for (int a = 0; a < 16; a += 4) begin
      bus(1'b0, a[3:0], 32'h0);
      chk("reg", 0, rd);
    end
  endtask
  task automatic t_legacy();
    put(1'b0, 20'h00001, 16'h0001, 16'h0005);
    bus(1'b0, 4'h4, 32'h0);
    chk("count", 0, rd);
    look(1'b1, 20'h00001, 16'h0001);
    chk("hit", 0, lk_hit_q);
  endtask
  task automatic t_scalable();
    bus(1'b1, 4'h0, 32'h00000002);
    put(1'b1, 20'h00002, 16'h0001, 16'h0005);
    bus(1'b0, 4'h4, 32'h0);
    chk("count", 0, rd);
    put(1'b0, 20'h00002, 16'h0001, 16'h0005);
    look(1'b0, 20'h00002, 16'h0001);
    chk("hit", 1, lk_hit_q);
    chk("fault", 0, lk_fault_q);
    chk("did", 16'h0005, lk_did_q);
    chk("data", {28'h0, 20'h00002, 16'h0005}, lk_data_q);
    look(1'b1, 20'h00002, 16'h0002);
    chk("hit", 0, lk_hit_q);
  endtask
  task automatic t_fault_cache();
    bus(1'b1, 4'h0, 32'h00000003);
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl", 3, rd);
    put(1'b1, 20'h00003, 16'h0001, 16'h0007);
    look(1'b1, 20'h00003, 16'h0001);
    chk("hit", 1, lk_hit_q);
    chk("fault", 1, lk_fault_q);
    chk("did", 16'h0000, lk_did_q);
  endtask
  task automatic t_shared_pasid();
    for (int s = 1; s < 4; s++) put(1'b0, 20'h00004, s[15:0], 16'h0009);
    put(1'b0, 20'h00004, 16'h0001, 16'h0009);
    for (int s = 1; s < 4; s++) begin
      look(1'b1, 20'h00004, s[15:0]);
      chk("hit", 1, lk_hit_q);
    end
    bus(1'b0, 4'h4, 32'h0);
    chk("count", 5, rd);
    // Third new source fills the last slot, the fourth replaces the oldest
    for (int s = 1; s < 5; s++) put(1'b0, 20'h00005, s[15:0], 16'h000B);
    bus(1'b0, 4'h4, 32'h0);
    chk("count", 8, rd);
    look(1'b1, 20'h00002, 16'h0001);
    chk("hit", 0, lk_hit_q);
    look(1'b1, 20'h00005, 16'h0004);
    chk("hit", 1, lk_hit_q);
    chk("fault", 0, lk_fault_q);
    chk("did", 16'h000B, lk_did_q);
  endtask
  // Software side drops stale faulting entries, then all
  task automatic t_invalidate();
    bus(1'b1, 4'h8, 32'h00000003);
    look(1'b1, 20'h00003, 16'h0001);
    chk("hit", 0, lk_hit_q);
    bus(1'b1, 4'h8, 32'h80000000);
    bus(1'b0, 4'h4, 32'h0);
    chk("count", 0, rd);
  endtask
  initial begin
    {arst_n, avs_read, avs_write, lk_valid, lk_has_pasid, go, bad} = '0;
    {avs_address, avs_writedata, lk_pasid, ctx_default_pasid, lk_sid} = '0;
    {pasid, sid, did, fail_count, comparisons} = '0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    t_regs();
    t_legacy();
    t_scalable();
    t_fault_cache();
    t_shared_pasid();
    t_invalidate();
    stop_test();
  end
endmodule
`default_nettype wire
